// ### iamc_addr_match.sv
// iamc_addr_match: match registers, address compare and capture registers.
// assumes mode and received-address strobes come from logic on clk_i.
// Notes on behaviour
// - 7-bit client capture keeps R/W in bit0
// - 10-bit client captures matched low byte
// - 10-bit host sends low byte from capture
// - low capture writable only in 10-bit host
// - 10-bit client captures high byte plus R/W
// - 7-bit host sends high capture address, R/W
// - 10-bit host sends high capture byte, R/W
// - high capture read-only in client modes
// - 7-bit compare uses first match bits 7:1
// - 10-bit first address low from first match
// - unmasked 7-bit second register is address
// - masked 7-bit second register masks first
// - unmasked 10-bit header and msbs in second
// - masked 10-bit header and msbs in second
// - header bits must match received exactly
// - unmasked 7-bit third register is address
// - masked 7-bit third register is address
// - unmasked 10-bit second address low byte
// - masked 10-bit third register is mask
// - masked 7-bit fourth register masks third
// - unmasked 10-bit second address msbs fourth
//
// Decided for this implementation: strobed register access.
`timescale 1ns/100ps
module iamc_addr_match (
    input  wire logic                   clk_i,
    input  wire logic                   rstn_i,
    input  wire logic [iamc_pkg::AW-1:0] addr_i,
    input  wire logic [iamc_pkg::DW-1:0] wdata_i,
    input  wire logic                   wr_i,
    input  wire logic                   rd_i,
    output logic      [iamc_pkg::DW-1:0] rdata_o,
    input  wire logic [2:0]             mode_i,
    input  wire logic                   rx_addr_valid_i,
    input  wire logic [7:0]             rx_addr_byte_i,
    input  wire logic                   rx_addr_low_i,
    output logic                        match_o,
    output logic      [7:0]             host_addr_high_o,
    output logic      [7:0]             host_addr_low_o
);
    import iamc_pkg::*;

    // ==========================================================
    // state
    typedef struct packed {
        logic [7:0]  cap_low;
        logic [7:0]  cap_high;
        logic [7:0]  m_first;
        logic [7:0]  m_first_um;
        logic [7:0]  m_second;
        logic [7:0]  m_second_um;
        logic [7:0]  hi_byte;
        logic [1:0]  hi_hit;
        iamc_phase_e phase;
        logic [7:0]  rdata;
        logic        match;
    } iamc_state_s;

    iamc_state_s r;
    iamc_state_s next_r;

    // compare under mask; set mask bits are don't care
    function automatic logic iamc_eq(input logic [7:0] a, input logic [7:0] b,
                                     input logic [7:0] m);
        return ((a ^ b) & ~m) == 8'h00;
    endfunction

    logic       is_c7;
    logic       is_mask7;
    logic [7:0] b;
    assign b        = rx_addr_byte_i;
    assign is_c7    = (mode_i == MODE_C7) || (mode_i == MODE_C7_MASK)
                   || (mode_i == MODE_MH7) || (mode_i == MODE_MH7_MASK);
    assign is_mask7 = (mode_i == MODE_C7_MASK) || (mode_i == MODE_MH7_MASK);

    // ==========================================================
    // next-state logic
    always_comb begin
        logic       hit7;
        logic [1:0] hh;
        logic       hit10;
        hit7   = 1'b0;
        hh     = 2'b00;
        hit10  = 1'b0;
        next_r = r;
        next_r.match = 1'b0;
        next_r.rdata = RD_ZERO;
        // register reads, data valid one cycle later
        if (rd_i) begin
            case (addr_i)
                OFS_CAPTURE_LOW:     next_r.rdata = r.cap_low;
                OFS_CAPTURE_HIGH:    next_r.rdata = r.cap_high;
                OFS_MATCH_FIRST:     next_r.rdata = r.m_first;
                OFS_MATCH_FIRST_UM:  next_r.rdata = r.m_first_um;
                OFS_MATCH_SECOND:    next_r.rdata = r.m_second;
                OFS_MATCH_SECOND_UM: next_r.rdata = r.m_second_um;
                default:             next_r.rdata = RD_ZERO;
            endcase
        end
        // register writes; capture writes gated by mode
        if (wr_i) begin
            case (addr_i)
                OFS_CAPTURE_LOW: begin
                    if (mode_i == MODE_H10) next_r.cap_low = wdata_i;
                end
                OFS_CAPTURE_HIGH: begin
                    if (mode_i[MODE_HOST_BIT]) next_r.cap_high = wdata_i;
                end
                OFS_MATCH_FIRST:     next_r.m_first     = wdata_i;
                OFS_MATCH_FIRST_UM:  next_r.m_first_um  = wdata_i;
                OFS_MATCH_SECOND:    next_r.m_second    = wdata_i;
                OFS_MATCH_SECOND_UM: next_r.m_second_um = wdata_i;
                default: ;
            endcase
        end
        // address compare; hardware capture applied after writes so it wins
        if (rx_addr_valid_i) begin
            if (is_c7) begin
                if (is_mask7) begin
                    hit7 = iamc_eq(b, r.m_first, {r.m_first_um[7:1], 1'b1})
                        || iamc_eq(b, r.m_second, {r.m_second_um[7:1], 1'b1});
                end else begin
                    hit7 = iamc_eq(b, r.m_first, 8'h01)
                        || iamc_eq(b, r.m_first_um, 8'h01)
                        || iamc_eq(b, r.m_second, 8'h01)
                        || iamc_eq(b, r.m_second_um, 8'h01);
                end
                if (hit7) begin
                    next_r.cap_low = b;
                    next_r.match   = 1'b1;
                end
                next_r.phase = IAMC_PH_IDLE;
            end else if (mode_i == MODE_C10 || mode_i == MODE_C10_MASK) begin
                if (!rx_addr_low_i) begin
                    // high byte: header must agree bit for bit
                    if (mode_i == MODE_C10) begin
                        hh[0] = iamc_eq(b, r.m_first_um, 8'h01);
                        hh[1] = iamc_eq(b, r.m_second_um, 8'h01);
                    end else begin
                        hh[0] = iamc_eq(b, r.m_first_um,
                                        {5'h00, r.m_second_um[2:1], 1'b1});
                    end
                    next_r.hi_hit  = hh;
                    next_r.hi_byte = b;
                    next_r.phase   = (hh != 2'b00) ? IAMC_PH_HIGH : IAMC_PH_IDLE;
                end else if (r.phase == IAMC_PH_HIGH) begin
                    if (mode_i == MODE_C10) begin
                        hit10 = (r.hi_hit[0] && b == r.m_first)
                             || (r.hi_hit[1] && b == r.m_second);
                    end else begin
                        hit10 = r.hi_hit[0] && iamc_eq(b, r.m_first, r.m_second);
                    end
                    if (hit10) begin
                        next_r.cap_low  = b;
                        next_r.cap_high = r.hi_byte;
                        next_r.match    = 1'b1;
                    end
                    next_r.phase = IAMC_PH_IDLE;
                end
            end
        end
    end

    // ==========================================================
    // state register, synchronous active-low reset
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            r.cap_low     <= RST_CAPTURE;
            r.cap_high    <= RST_CAPTURE;
            r.m_first     <= RST_MATCH;
            r.m_first_um  <= RST_MATCH;
            r.m_second    <= RST_MATCH;
            r.m_second_um <= RST_MATCH;
            r.hi_byte     <= RST_CAPTURE;
            r.hi_hit      <= 2'b00;
            r.phase       <= IAMC_PH_IDLE;
            r.rdata       <= RD_ZERO;
            r.match       <= 1'b0;
        end else begin
            r <= next_r;
        end
    end

    // host transmit address straight from capture registers
    assign host_addr_high_o = r.cap_high;
    assign host_addr_low_o  = r.cap_low;
    assign rdata_o          = r.rdata;
    assign match_o          = r.match;

endmodule

// ### iamc_pkg.sv
// iamc_pkg: constants for the serial bus address match and capture block.
// assumes an 8-bit register port with 12-bit byte addresses.
package iamc_pkg;

    // ==========================================================
    // register map
    localparam int unsigned AW = 12;
    localparam int unsigned DW = 8;
    localparam logic [11:0] OFS_CAPTURE_LOW  = 12'h28e;
    localparam logic [11:0] OFS_CAPTURE_HIGH = 12'h28f;
    localparam logic [11:0] OFS_MATCH_FIRST  = 12'h290;
    localparam logic [11:0] OFS_MATCH_FIRST_UM  = 12'h291;
    localparam logic [11:0] OFS_MATCH_SECOND    = 12'h292;
    localparam logic [11:0] OFS_MATCH_SECOND_UM = 12'h293;

    // ==========================================================
    // reset values
    localparam logic [7:0] RST_CAPTURE = 8'h00;
    localparam logic [7:0] RST_MATCH   = 8'hff;
    localparam logic [7:0] RD_ZERO     = 8'h00;

    // ==========================================================
    // mode field encodings
    localparam logic [2:0] MODE_C7      = 3'h0;
    localparam logic [2:0] MODE_C7_MASK = 3'h1;
    localparam logic [2:0] MODE_C10     = 3'h2;
    localparam logic [2:0] MODE_C10_MASK = 3'h3;
    localparam logic [2:0] MODE_H7      = 3'h4;
    localparam logic [2:0] MODE_H10     = 3'h5;
    localparam logic [2:0] MODE_MH7     = 3'h6;
    localparam logic [2:0] MODE_MH7_MASK = 3'h7;
    localparam int unsigned MODE_HOST_BIT = 2;

    // 10-bit receive phase
    typedef enum logic [0:0] {
        IAMC_PH_IDLE = 1'b0,
        IAMC_PH_HIGH = 1'b1
    } iamc_phase_e;

endpackage

// ### iamc_addr_match_monitor.sv
// port checks for iamc_addr_match
// assumes one clock domain and the low synchronous reset
`timescale 1ns/100ps
module iamc_addr_match_monitor
    import iamc_pkg::*;
(
    input wire logic        clk_i,
    input wire logic        rstn_i,
    input wire logic [11:0] addr_i,
    input wire logic [7:0]  wdata_i,
    input wire logic        wr_i,
    input wire logic [2:0]  mode_i,
    input wire logic        rx_addr_valid_i,
    input wire logic [7:0]  rx_addr_byte_i,
    input wire logic        rx_addr_low_i,
    input wire logic        match_o,
    input wire logic [7:0]  host_addr_high_o,
    input wire logic [7:0]  host_addr_low_o
);
    logic [7:0] wd;
    logic [7:0] rxb;
    // ====
    // last written and received bytes, so checks need no local variables
    always_ff @(posedge clk_i) begin
        if (wr_i) wd <= wdata_i;
        if (rx_addr_valid_i) rxb <= rx_addr_byte_i;
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rstn_i);
    chk_match_cause: assert property (match_o |-> $past(rx_addr_valid_i))
        else $error("match without byte");
    chk_host_ignore: assert property (rx_addr_valid_i && mode_i[2:1] == 2'b10 |=> !match_o)
        else $error("match in host mode");
    chk_cap_hold: assert property (!match_o && !$past(match_o) && !$past(wr_i)
        && !$past(wr_i, 2) |-> $stable(host_addr_low_o)) else $error("capture moved");
    chk_low_write: assert property (wr_i && addr_i == OFS_CAPTURE_LOW
        && mode_i == MODE_H10 |=> ##[0:1] host_addr_low_o == wd) else $error("low lost");
    chk_high_write: assert property (wr_i && addr_i == OFS_CAPTURE_HIGH
        && mode_i[2] |=> ##[0:1] host_addr_high_o == wd) else $error("high lost");
    chk_high_ro: assert property (wr_i && addr_i == OFS_CAPTURE_HIGH && !mode_i[2]
        |=> ($stable(host_addr_high_o) || match_o) [*2]) else $error("high written");
    chk_c7_cap: assert property (rx_addr_valid_i && mode_i == MODE_C7 ##1 match_o
        |-> ##[0:1] host_addr_low_o == rxb) else $error("7-bit capture");
    chk_c10_cap: assert property (rx_addr_valid_i && rx_addr_low_i
        && mode_i[2:1] == 2'b01 ##1 match_o |-> ##[0:1] host_addr_low_o == rxb)
        else $error("10-bit capture");
endmodule
bind iamc_addr_match iamc_addr_match_monitor mon (.clk_i(clk_i), .rstn_i(rstn_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .mode_i(mode_i),
    .rx_addr_valid_i(rx_addr_valid_i), .rx_addr_byte_i(rx_addr_byte_i),
    .rx_addr_low_i(rx_addr_low_i), .match_o(match_o),
    .host_addr_high_o(host_addr_high_o), .host_addr_low_o(host_addr_low_o));

// ### iamc_bus_host.sv
// far-side host sending address bytes toward the block
// assumes send is called by one process at a time
`timescale 1ns/100ps
module iamc_bus_host (
    input  wire logic       clk_i,
    output logic            valid_o,
    output logic      [7:0] byte_o,
    output logic            low_o
);
    // ====
    // idle lines show the inverse, so a stale byte never passes as fresh
    initial valid_o = 1'b0;
    task automatic send(input logic [7:0] b, input logic l);
        @(posedge clk_i);
        valid_o <= 1'b1;
        byte_o  <= b;
        low_o   <= l;
        @(posedge clk_i);
        valid_o <= 1'b0;
        byte_o  <= ~b;
        low_o   <= ~l;
    endtask
endmodule

// ### iamc_addr_match_bench.sv
// bench for iamc_addr_match: register and address receive sequences
// assumes the bus host model drives the receive side
`timescale 1ns/100ps
module iamc_addr_match_bench;
    import iamc_pkg::*;
    logic        clk = 1'b0;
    logic        rstn = 1'b0;
    logic [11:0] ad = 12'h000;
    logic [7:0]  wd = 8'h00;
    logic        wr = 1'b0;
    logic        rd = 1'b0;
    logic [2:0]  md = MODE_C7;
    logic [7:0]  rdat, rb, hh, hl;
    logic        rv, rl, mt;
    int          error_cnt = 0;
    int          n_checks = 0;
    int          cyc = 0;
    // ====
    // 4 ns clock
    always #2 clk = ~clk;
    iamc_addr_match iamc_addr_match_inst (.clk_i(clk), .rstn_i(rstn), .addr_i(ad),
        .wdata_i(wd), .wr_i(wr), .rd_i(rd), .rdata_o(rdat), .mode_i(md),
        .rx_addr_valid_i(rv), .rx_addr_byte_i(rb), .rx_addr_low_i(rl), .match_o(mt),
        .host_addr_high_o(hh), .host_addr_low_o(hl));
    iamc_bus_host host (.clk_i(clk), .valid_o(rv), .byte_o(rb), .low_o(rl));
    task automatic give_verdict;
        $display("checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic ck(input logic [7:0] g, input logic [7:0] e);
        n_checks++;
        if (g !== e) begin
            error_cnt++;
            $display("[FAIL] %0t got %h want %h", $time, g, e);
        end
    endtask
    task automatic w(input logic [11:0] a, input logic [7:0] d);
        @(posedge clk);
        {wr, ad, wd} <= {1'b1, a, d};
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic r(input logic [11:0] a, input logic [7:0] e);
        @(posedge clk);
        {rd, ad} <= {1'b1, a};
        @(posedge clk);
        rd <= 1'b0;
        #1 ck(rdat, e);
    endtask
    task automatic rx(input logic [7:0] b, input logic l, input logic m);
        host.send(b, l);
        #1 ck({7'h00, mt}, {7'h00, m});
    endtask
    // hang guard, far above the hundred or so cycles the sequence needs
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            error_cnt++;
            give_verdict;
        end
    end
    // main sequence
    initial begin
        repeat (6) @(posedge clk);
        rstn <= 1'b1;
        r(OFS_CAPTURE_HIGH, RST_CAPTURE);
        r(OFS_MATCH_SECOND, RST_MATCH);
        r(12'h28a, RD_ZERO);
        w(OFS_CAPTURE_LOW, 8'h55);
        w(OFS_CAPTURE_HIGH, 8'h77);
        r(OFS_CAPTURE_LOW, RST_CAPTURE);
        r(OFS_CAPTURE_HIGH, RST_CAPTURE);
        w(OFS_MATCH_FIRST, 8'ha1);
        w(OFS_MATCH_FIRST_UM, 8'h30);
        w(OFS_MATCH_SECOND, 8'h63);
        rx(8'ha0, 1'b0, 1'b1);
        rx(8'h31, 1'b0, 1'b1);
        rx(8'h62, 1'b0, 1'b1);
        rx(8'h44, 1'b0, 1'b0);
        r(OFS_CAPTURE_LOW, 8'h62);
        md <= MODE_C7_MASK;
        w(OFS_MATCH_FIRST_UM, 8'h06);
        w(OFS_MATCH_SECOND_UM, 8'h02);
        rx(8'ha7, 1'b0, 1'b1);
        rx(8'h31, 1'b0, 1'b0);
        rx(8'h60, 1'b0, 1'b1);
        rx(8'hb1, 1'b0, 1'b0);
        md <= MODE_MH7_MASK;
        rx(8'h61, 1'b0, 1'b1);
        md <= MODE_C10;
        w(OFS_MATCH_FIRST_UM, 8'hf2);
        w(OFS_MATCH_FIRST, 8'h34);
        w(OFS_MATCH_SECOND_UM, 8'hf5);
        w(OFS_MATCH_SECOND, 8'h56);
        host.send(8'he2, 1'b0);
        rx(8'h34, 1'b1, 1'b0);
        host.send(8'hf3, 1'b0);
        rx(8'h34, 1'b1, 1'b1);
        r(OFS_CAPTURE_HIGH, 8'hf3);
        host.send(8'hf4, 1'b0);
        rx(8'h56, 1'b1, 1'b1);
        r(OFS_CAPTURE_LOW, 8'h56);
        md <= MODE_C10_MASK;
        w(OFS_MATCH_SECOND, 8'h0f);
        w(OFS_MATCH_SECOND_UM, 8'hf2);
        host.send(8'hf0, 1'b0);
        rx(8'h3b, 1'b1, 1'b1);
        host.send(8'hf2, 1'b0);
        rx(8'h44, 1'b1, 1'b0);
        md <= MODE_H10;
        w(OFS_CAPTURE_LOW, 8'h3c);
        w(OFS_CAPTURE_HIGH, 8'hf1);
        r(OFS_CAPTURE_LOW, 8'h3c);
        ck(hl, 8'h3c);
        ck(hh, 8'hf1);
        md <= MODE_H7;
        w(OFS_CAPTURE_LOW, 8'h99);
        w(OFS_CAPTURE_HIGH, 8'h52);
        r(OFS_CAPTURE_LOW, 8'h3c);
        ck(hh, 8'h52);
        rx(8'h52, 1'b0, 1'b0);
        give_verdict;
    end
endmodule
